// *** design/cpu_alu_consts.svh ***
`ifndef CPU_ALU_CONSTS_SVH
`define CPU_ALU_CONSTS_SVH
// Byte addresses on the register bus
`define ADR_STATUS      8'h00
`define ADR_CORE_CTRL   8'h04
`define ADR_MEM_OPND    8'h08
`define ADR_MEM_RESULT  8'h0c
`define ADR_COMMAND     8'h10
`define ADR_SYS_CTRL    8'h14
`define ADR_WREG_BASE   8'h40
// Status field positions
`define ST_C            0
`define ST_Z            1
`define ST_OV           2
`define ST_N            3
`define ST_RA           4
`define ST_IPL_LO       5
`define ST_DC           8
// Core-control field positions
`define CC_PSV          2
`define CC_PRIORITY_LEVEL_HIGH_BIT         3
// Command field positions
`define CMD_BYTE        5
`define CMD_MEM_SRC     6
`define CMD_MEM_DST     7
`define CMD_SRCA_LO     8
`define CMD_SRCB_LO     12
`define CMD_DST_LO      16
`define CMD_SHAMT_LO    20
// Reset values
`define STATUS_RESET    16'h0000
`define CORE_CTRL_RESET 16'h0000
// Divider timing and the fully masked priority level
`define DIV_ITERATIONS  5'h10
`define DIV_TOTAL_CYCLES 19
`define IPL_ALL_MASKED  3'h7
`endif

// *** design/cpu_alu_pkg.sv ***
`default_nettype none
package cpu_alu_pkg;
	typedef enum logic [4:0] {
		OP_ADD = 5'h00, OP_SUB = 5'h01, OP_AND = 5'h02, OP_IOR = 5'h03,
		OP_XOR = 5'h04, OP_SHL = 5'h05, OP_SHA = 5'h06,
		OP_MUL_SS = 5'h08, OP_MUL_UU = 5'h09, OP_MUL_US = 5'h0a,
		OP_MUL_SU = 5'h0b, OP_MUL_SL = 5'h0c, OP_MUL_UL = 5'h0d,
		OP_MUL_BB = 5'h0e,
		OP_DIV_S32 = 5'h10, OP_DIV_U32 = 5'h11, OP_DIV_S16 = 5'h12,
		OP_DIV_U16 = 5'h13
	} alu_op_t;
	typedef enum logic [2:0] {
		DIV_IDLE  = 3'h0,
		DIV_SETUP = 3'h1,
		DIV_ITER  = 3'h3,
		DIV_FIX   = 3'h2,
		DIV_WRITE = 3'h6
	} div_state_t;
	typedef struct packed {
		logic [15:0] res;
		logic        c;
		logic        dc;
		logic        n;
		logic        ov;
		logic        z;
	} alu_out_t;
endpackage : cpu_alu_pkg
`default_nettype wire

// *** design/cpu_alu_status_datapath.sv ***
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_alu_consts.svh"
module cpu_alu_status_datapath (
	input  wire logic        core_clk,               // Core clock, 40 MHz
	input  wire logic        rst,                    // Sync reset, high
	input  wire logic        clkEn,                  // Freezes state when low
	input  wire logic        wb_cyc_i,               // Bus cycle
	input  wire logic        wb_stb_i,               // Bus strobe
	input  wire logic        wb_we_i,                // Bus write
	input  wire logic [7:0]  wb_adr_i,               // Byte address
	input  wire logic [31:0] wb_dat_i,               // Write data
	input  wire logic [3:0]  wb_sel_i,               // Byte enables
	input  wire logic        priorityHighSet,        // Raise level above 7
	output logic      [31:0] wb_dat_o,               // Read data
	output logic             wb_ack_o,               // Bus acknowledge
	output logic      [3:0]  cpuPriority,            // Combined level
	output logic             userIntDisable,         // User interrupts off
	output logic             programSpaceViewEnable, // Program in data space
	output logic             repeatActive            // Divide loop running
);
	logic [15:0] wregs [16];
	logic [15:0] memOperand;
	logic [15:0] memResult;
	logic        halfCarryFlag;
	logic [2:0]  priorityFieldLow;
	logic        repeatActiveFlag;
	logic        negFlag;
	logic        overflowFlag;
	logic        zeroFlag;
	logic        carryFlag;
	logic        priorityLevelHighBit;
	logic        psvBit;
	logic        interruptNestingDisable;
	cpu_alu_pkg::div_state_t divState;
	logic [4:0]  divCount;
	logic [15:0] divRem;
	logic [15:0] divQuot;
	logic [15:0] divLow;
	logic [15:0] divisor;
	logic        quotNeg;
	logic        remNeg;
	logic        divSigned;
	logic        busAccess;
	logic        busWrite;
	logic [7:0]  wordAdr;
	logic        cmdGo;
	cpu_alu_pkg::alu_op_t cmdOp;
	logic [15:0] opA;
	logic [15:0] opB;
	logic [3:0]  dstIdx;
	logic [31:0] cmdData;
	cpu_alu_pkg::alu_out_t aluOut;
	logic        aluFlagsAll;
	logic        aluFlagsNz;
	logic        isMul;
	logic        isDiv;
	logic [31:0] product;
	logic [15:0] statusWord;
	logic [15:0] coreWord;
	logic [31:0] dividend;
	logic [16:0] trial;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] din, input logic [1:0] sel);
		merge = {sel[1] ? din[15:8] : old[15:8], sel[0] ? din[7:0] : old[7:0]};
	endfunction : merge

	function automatic cpu_alu_pkg::alu_out_t add_sub(input logic [15:0] a,
		input logic [15:0] b, input logic sub, input logic byteMode);
		logic [15:0] bb;
		logic [16:0] sum;
		logic [8:0]  low;
		logic [4:0]  nib;
		cpu_alu_pkg::alu_out_t o;
		bb = sub ? ~b : b;
		sum = {1'b0, a} + {1'b0, bb} + {16'h0000, sub};
		low = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, sub};
		nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
		o.res = sum[15:0];
		if (byteMode) begin
			o.c = low[8];
			o.dc = nib[4];
			o.n = sum[7];
			o.ov = (a[7] == bb[7]) && (sum[7] != a[7]);
			o.z = sum[7:0] == 8'h00;
		end else begin
			o.c = sum[16];
			o.dc = low[8];
			o.n = sum[15];
			o.ov = (a[15] == bb[15]) && (sum[15] != a[15]);
			o.z = sum[15:0] == 16'h0000;
		end
		add_sub = o;
	endfunction : add_sub

	function automatic logic [15:0] shift(input logic [15:0] a,
		input logic [5:0] amt, input logic arith);
		logic [5:0]  mag;
		logic [16:0] ext;
		mag = amt[5] ? 6'(-amt) : amt;
		if (mag > 6'h10)
			mag = 6'h10;
		ext = {arith & a[15], a};
		if (amt[5])
			shift = a << mag;
		else
			shift = 16'($signed(ext) >>> mag);
	endfunction : shift

	function automatic logic [31:0] mul17(input logic [15:0] a,
		input logic [15:0] b, input logic sa, input logic sb);
		logic signed [33:0] p;
		p = $signed({sa & a[15], a}) * $signed({sb & b[15], b});
		mul17 = p[31:0];
	endfunction : mul17

	function automatic logic [15:0] neg_if(input logic [15:0] v,
		input logic n);
		neg_if = n ? 16'(-v) : v;
	endfunction : neg_if

	assign busAccess = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign busWrite = busAccess && wb_we_i;
	assign wordAdr = {wb_adr_i[7:2], 2'b00};
	assign cmdData = wb_dat_i;
	assign cmdOp = cpu_alu_pkg::alu_op_t'(cmdData[4:0]);
	assign cmdGo = busWrite && wordAdr == `ADR_COMMAND && wb_sel_i == 4'hf
		&& divState == cpu_alu_pkg::DIV_IDLE;
	assign opA = cmdData[`CMD_MEM_SRC] ? memOperand
		: wregs[cmdData[`CMD_SRCA_LO +: 4]];
	assign opB = wregs[cmdData[`CMD_SRCB_LO +: 4]];
	assign dstIdx = cmdData[`CMD_DST_LO +: 4];
	assign isMul = cmdData[4:3] == 2'b01;
	assign isDiv = cmdData[4];
	assign aluFlagsAll = cmdOp == cpu_alu_pkg::OP_ADD
		|| cmdOp == cpu_alu_pkg::OP_SUB;
	assign aluFlagsNz = !isMul && !isDiv && !aluFlagsAll;

	always_comb begin
		aluOut = add_sub(opA, opB, cmdOp == cpu_alu_pkg::OP_SUB,
			cmdData[`CMD_BYTE]);
		case (cmdOp)
			cpu_alu_pkg::OP_AND: aluOut.res = opA & opB;
			cpu_alu_pkg::OP_IOR: aluOut.res = opA | opB;
			cpu_alu_pkg::OP_XOR: aluOut.res = opA ^ opB;
			cpu_alu_pkg::OP_SHL: aluOut.res = shift(opA,
				cmdData[`CMD_SHAMT_LO +: 6], 1'b0);
			cpu_alu_pkg::OP_SHA: aluOut.res = shift(opA,
				cmdData[`CMD_SHAMT_LO +: 6], 1'b1);
			default: aluOut.res = aluOut.res;
		endcase
		if (aluFlagsNz) begin
			aluOut.n = cmdData[`CMD_BYTE] ? aluOut.res[7] : aluOut.res[15];
			aluOut.z = cmdData[`CMD_BYTE] ? aluOut.res[7:0] == 8'h00
				: aluOut.res == 16'h0000;
		end
	end

	always_comb begin
		case (cmdOp)
			cpu_alu_pkg::OP_MUL_SS: product = mul17(opA, opB, 1'b1, 1'b1);
			cpu_alu_pkg::OP_MUL_US: product = mul17(opA, opB, 1'b0, 1'b1);
			cpu_alu_pkg::OP_MUL_SU: product = mul17(opA, opB, 1'b1, 1'b0);
			cpu_alu_pkg::OP_MUL_SL: product = mul17(opA,
				{11'h000, cmdData[`CMD_SRCB_LO +: 5]}, 1'b1, 1'b0);
			cpu_alu_pkg::OP_MUL_UL: product = mul17(opA,
				{11'h000, cmdData[`CMD_SRCB_LO +: 5]}, 1'b0, 1'b0);
			cpu_alu_pkg::OP_MUL_BB: product = mul17({8'h00, opA[7:0]},
				{8'h00, opB[7:0]}, 1'b0, 1'b0);
			default: product = mul17(opA, opB, 1'b0, 1'b0);
		endcase
	end

	assign dividend = (cmdOp == cpu_alu_pkg::OP_DIV_S32
		|| cmdOp == cpu_alu_pkg::OP_DIV_U32)
		? {wregs[{cmdData[`CMD_SRCA_LO + 1 +: 3], 1'b1}],
			wregs[{cmdData[`CMD_SRCA_LO + 1 +: 3], 1'b0}]}
		: {{16{cmdOp == cpu_alu_pkg::OP_DIV_S16 && opA[15]}}, opA};
	assign trial = {divRem, divLow[15]} - {1'b0, divisor};

	// Operands are captured at the command, so bus writes to the source
	// registers during the loop cannot corrupt the division.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			divState <= cpu_alu_pkg::DIV_IDLE;
			divCount <= 5'h00;
			divRem <= 16'h0000;
			divQuot <= 16'h0000;
			divLow <= 16'h0000;
			divisor <= 16'h0000;
			quotNeg <= 1'b0;
			remNeg <= 1'b0;
			divSigned <= 1'b0;
		end else if (clkEn) begin
			case (divState)
				cpu_alu_pkg::DIV_IDLE: begin
					if (cmdGo && isDiv) begin
						divSigned <= !cmdData[0];
						divRem <= dividend[31:16];
						divLow <= dividend[15:0];
						divisor <= opB;
						quotNeg <= !cmdData[0] && (dividend[31] ^ opB[15]);
						remNeg <= !cmdData[0] && dividend[31];
						divState <= cpu_alu_pkg::DIV_SETUP;
					end
				end
				cpu_alu_pkg::DIV_SETUP: begin
					if (divSigned) begin
						{divRem, divLow} <= remNeg ? 32'(-{divRem, divLow})
							: {divRem, divLow};
						divisor <= neg_if(divisor, divisor[15]);
					end
					divCount <= `DIV_ITERATIONS;
					divState <= cpu_alu_pkg::DIV_ITER;
				end
				cpu_alu_pkg::DIV_ITER: begin
					if (!trial[16] || divRem[15])
						divRem <= trial[15:0];
					else
						divRem <= {divRem[14:0], divLow[15]};
					divQuot <= {divQuot[14:0], !trial[16] || divRem[15]};
					divLow <= {divLow[14:0], 1'b0};
					divCount <= divCount - 5'h01;
					if (divCount == 5'h01)
						divState <= cpu_alu_pkg::DIV_FIX;
				end
				cpu_alu_pkg::DIV_FIX: begin
					divQuot <= neg_if(divQuot, quotNeg);
					divRem <= neg_if(divRem, remNeg);
					divState <= cpu_alu_pkg::DIV_WRITE;
				end
				cpu_alu_pkg::DIV_WRITE: divState <= cpu_alu_pkg::DIV_IDLE;
				default: divState <= cpu_alu_pkg::DIV_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			repeatActiveFlag <= 1'b0;
		else if (clkEn)
			repeatActiveFlag <= (cmdGo && isDiv)
				|| (repeatActiveFlag && divState != cpu_alu_pkg::DIV_WRITE);
	end

	// Datapath results beat a bus write to the same register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < 16; i++)
				wregs[i] <= 16'h0000;
			memOperand <= 16'h0000;
			memResult <= 16'h0000;
		end else if (clkEn) begin
			if (busWrite && wordAdr == `ADR_MEM_OPND)
				memOperand <= merge(memOperand, wb_dat_i[15:0], wb_sel_i[1:0]);
			if (busWrite && wb_adr_i[7:6] == 2'b01)
				wregs[wb_adr_i[5:2]] <= merge(wregs[wb_adr_i[5:2]],
					wb_dat_i[15:0], wb_sel_i[1:0]);
			if (cmdGo && isMul) begin
				wregs[{dstIdx[3:1], 1'b0}] <= product[15:0];
				wregs[{dstIdx[3:1], 1'b1}] <= product[31:16];
			end else if (cmdGo && !isDiv) begin
				if (cmdData[`CMD_MEM_DST])
					memResult <= cmdData[`CMD_BYTE]
						? {memResult[15:8], aluOut.res[7:0]} : aluOut.res;
				else
					wregs[dstIdx] <= cmdData[`CMD_BYTE]
						? {wregs[dstIdx][15:8], aluOut.res[7:0]} : aluOut.res;
			end
			if (divState == cpu_alu_pkg::DIV_WRITE) begin
				wregs[0] <= divQuot;
				wregs[1] <= divRem;
			end
		end
	end

	// Flag updates from an operation win over a software write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{halfCarryFlag, negFlag, overflowFlag, zeroFlag, carryFlag}
				<= 5'h00;
			priorityFieldLow <= 3'h0;
		end else if (clkEn) begin
			if (busWrite && wordAdr == `ADR_STATUS) begin
				if (wb_sel_i[1])
					halfCarryFlag <= wb_dat_i[`ST_DC];
				if (wb_sel_i[0]) begin
					negFlag <= wb_dat_i[`ST_N];
					overflowFlag <= wb_dat_i[`ST_OV];
					zeroFlag <= wb_dat_i[`ST_Z];
					carryFlag <= wb_dat_i[`ST_C];
					if (!interruptNestingDisable)
						priorityFieldLow <= wb_dat_i[`ST_IPL_LO +: 3];
				end
			end
			if (cmdGo && aluFlagsAll) begin
				{halfCarryFlag, overflowFlag, carryFlag}
					<= {aluOut.dc, aluOut.ov, aluOut.c};
			end
			if (cmdGo && (aluFlagsAll || aluFlagsNz)) begin
				negFlag <= aluOut.n;
				zeroFlag <= aluOut.z;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			priorityLevelHighBit <= 1'b0;
			psvBit <= 1'b0;
			interruptNestingDisable <= 1'b0;
		end else if (clkEn) begin
			if (busWrite && wordAdr == `ADR_CORE_CTRL && wb_sel_i[0]) begin
				psvBit <= wb_dat_i[`CC_PSV];
				if (!wb_dat_i[`CC_PRIORITY_LEVEL_HIGH_BIT])
					priorityLevelHighBit <= 1'b0;
			end
			if (priorityHighSet)
				priorityLevelHighBit <= 1'b1;
			if (busWrite && wordAdr == `ADR_SYS_CTRL && wb_sel_i[0])
				interruptNestingDisable <= wb_dat_i[0];
		end
	end

	assign statusWord = {7'h00, halfCarryFlag, priorityFieldLow,
		repeatActiveFlag, negFlag, overflowFlag, zeroFlag, carryFlag};
	assign coreWord = {12'h000, priorityLevelHighBit, psvBit, 2'b00};

	// Registered ack: one wait state, unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (clkEn) begin
			wb_ack_o <= busAccess;
			wb_dat_o <= 32'h00000000;
			if (busAccess && !wb_we_i) begin
				case (wordAdr)
					`ADR_STATUS: wb_dat_o <= {16'h0000, statusWord};
					`ADR_CORE_CTRL: wb_dat_o <= {16'h0000, coreWord};
					`ADR_MEM_OPND: wb_dat_o <= {16'h0000, memOperand};
					`ADR_MEM_RESULT: wb_dat_o <= {16'h0000, memResult};
					`ADR_COMMAND: wb_dat_o <= {31'h00000000, repeatActiveFlag};
					`ADR_SYS_CTRL: wb_dat_o <= {31'h00000000,
						interruptNestingDisable};
					default: begin
						if (wb_adr_i[7:6] == 2'b01)
							wb_dat_o <= {16'h0000, wregs[wb_adr_i[5:2]]};
					end
				endcase
			end
		end
	end

	// Outputs lag the registers by one cycle to come from flops
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpuPriority <= 4'h0;
			userIntDisable <= 1'b0;
			programSpaceViewEnable <= 1'b0;
			repeatActive <= 1'b0;
		end else if (clkEn) begin
			cpuPriority <= {priorityLevelHighBit, priorityFieldLow};
			userIntDisable <= priorityLevelHighBit
				|| priorityFieldLow == `IPL_ALL_MASKED;
			programSpaceViewEnable <= psvBit;
			repeatActive <= repeatActiveFlag;
		end
	end

	sequence divLaunch;
		cmdGo && isDiv;
	endsequence
	sequence divBody;
		repeatActiveFlag ##18 repeatActiveFlag ##1 !repeatActiveFlag;
	endsequence

	chk_repeat_span: assert property (@(posedge core_clk)
		disable iff (rst || !clkEn) divLaunch |=> divBody)
		else $error("repeat-active span is not 19 cycles");
	chk_status_unimpl: assert property (@(posedge core_clk)
		disable iff (rst) wb_ack_o && !wb_we_i && wordAdr == `ADR_STATUS
		|-> wb_dat_o[31:9] == 23'h000000)
		else $error("unimplemented status bits read non-zero");
	chk_user_masked: assert property (@(posedge core_clk)
		disable iff (rst || !clkEn)
		(priorityFieldLow == 3'h7 || priorityLevelHighBit)
		|=> userIntDisable && cpuPriority[2:0] == $past(priorityFieldLow))
		else $error("user interrupts not disabled");
	chk_ipl_locked: assert property (@(posedge core_clk)
		disable iff (rst) interruptNestingDisable |=> $stable(priorityFieldLow))
		else $error("priority field changed while locked");
	chk_priority_level_high_bit_clear: assert property (@(posedge core_clk)
		disable iff (rst || !clkEn) !priorityLevelHighBit && !priorityHighSet
		|=> !priorityLevelHighBit)
		else $error("extra level bit set without hardware cause");
	chk_carry_word: assert property (@(posedge core_clk)
		disable iff (rst || !clkEn)
		cmdGo && cmdOp == cpu_alu_pkg::OP_ADD && !cmdData[`CMD_BYTE]
		|=> carryFlag == $past(({1'b0, opA} + {1'b0, opB}) > 17'h0ffff))
		else $error("word add carry wrong");
	chk_half_carry: assert property (@(posedge core_clk)
		disable iff (rst || !clkEn)
		cmdGo && cmdOp == cpu_alu_pkg::OP_ADD && cmdData[`CMD_BYTE]
		|=> halfCarryFlag
		== $past(({1'b0, opA[3:0]} + {1'b0, opB[3:0]}) > 5'h0f))
		else $error("byte half carry wrong");
	chk_shift_zero: assert property (@(posedge core_clk)
		disable iff (rst || !clkEn)
		cmdGo && cmdOp == cpu_alu_pkg::OP_SHL && !cmdData[`CMD_MEM_DST]
		&& cmdData[`CMD_SHAMT_LO +: 6] == 6'h00 && !cmdData[`CMD_BYTE]
		|=> wregs[$past(dstIdx)] == $past(opA))
		else $error("zero shift changed operand");
	chk_div_quot: assert property (@(posedge core_clk)
		disable iff (rst || !clkEn)
		cmdGo && cmdOp == cpu_alu_pkg::OP_DIV_U16 && opB != 16'h0000
		|=> ##19 wregs[0] == $past(opA / opB, 20)
		&& wregs[1] == $past(opA % opB, 20))
		else $error("divide results misplaced");
endmodule : cpu_alu_status_datapath
`default_nettype wire

// *** test/cpu_alu_status_datapath_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpu_alu_consts.svh"
module cpu_alu_status_datapath_tb;
	logic        core_clk;
	logic        rst;
	logic        clkEn;
	logic        wbCyc;
	logic        wbStb;
	logic        wbWe;
	logic [7:0]  wbAdr;
	logic [31:0] wbDatI;
	logic [3:0]  wbSel;
	logic        prioHighSet;
	logic [31:0] wbDatO;
	logic        wbAck;
	logic [3:0]  cpuPrio;
	logic        userIntOff;
	logic        psvOut;
	logic        raOut;
	logic [31:0] rdv;
	int          errors;
	int          compares;
	int          raRun;
	int          raLast;

	cpu_alu_status_datapath i_dut (
		.core_clk              (core_clk),
		.rst                   (rst),
		.clkEn                 (clkEn),
		.wb_cyc_i              (wbCyc),
		.wb_stb_i              (wbStb),
		.wb_we_i               (wbWe),
		.wb_adr_i              (wbAdr),
		.wb_dat_i              (wbDatI),
		.wb_sel_i              (wbSel),
		.priorityHighSet       (prioHighSet),
		.wb_dat_o              (wbDatO),
		.wb_ack_o              (wbAck),
		.cpuPriority           (cpuPrio),
		.userIntDisable        (userIntOff),
		.programSpaceViewEnable(psvOut),
		.repeatActive          (raOut)
	);

	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Length of the most recent high run of the repeat-active output
	always @(posedge core_clk) begin
		if (raOut === 1'h1) begin
			raRun <= raRun + 1;
		end else if (raRun != 0) begin
			raLast <= raRun;
			raRun <= 0;
		end
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Classic single cycle; the master never assumes the answer latency
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge core_clk);
		wbCyc <= 1'h1;
		wbStb <= 1'h1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= d;
		wbSel <= 4'hf;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wbAck !== 1'h1 && n < 50);
		if (wbAck !== 1'h1) begin
			chk("bus ack", 32'h1, {31'h0, wbAck});
			give_verdict();
		end
		q = wbDatO;
		wbCyc <= 1'h0;
		wbStb <= 1'h0;
		wbWe <= 1'h0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, q);
		chk(nm, e, q);
	endtask : rdc

	function automatic logic [7:0] wa(input logic [3:0] n);
		return `ADR_WREG_BASE + {2'h0, n, 2'h0};
	endfunction : wa

	function automatic logic [31:0] cmd(input logic [4:0] op,
		input logic byt, input logic [3:0] sa, input logic [3:0] sb,
		input logic [5:0] amt);
		return {6'h00, amt, 4'h2, sb, sa, 2'h0, byt, op};
	endfunction : cmd

	// Results land in W3:W2; W2 preset so byte ops show the kept high byte
	task automatic run_op(input logic [4:0] op, input logic byt,
		input logic [15:0] a, input logic [15:0] b, input logic [3:0] sb,
		input logic [5:0] amt, input logic [15:0] lo,
		input logic [15:0] hi, input logic [15:0] st);
		wr(wa(4'h4), {16'h0, a});
		wr(wa(sb), {16'h0, b});
		wr(wa(4'h2), 32'h0000cdcd);
		wr(wa(4'h3), 32'h0);
		wr(`ADR_STATUS, 32'h0);
		wr(`ADR_COMMAND, cmd(op, byt, 4'h4, sb, amt));
		rdc("result low", wa(4'h2), {16'h0, lo});
		rdc("result high", wa(4'h3), {16'h0, hi});
		rdc("flags", `ADR_STATUS, {16'h0, st});
	endtask : run_op

	task automatic test_regs();
		rdc("status reset", `ADR_STATUS, 32'h0);
		rdc("core reset", `ADR_CORE_CTRL, 32'h0);
		wr(`ADR_STATUS, 32'h0000ffff);
		rdc("status ro bits", `ADR_STATUS, 32'h000001ef);
		repeat (2) @(posedge core_clk);
		chk("level seven", 32'h17, {27'h0, userIntOff, cpuPrio});
		wr(`ADR_STATUS, 32'h00000060);
		repeat (2) @(posedge core_clk);
		chk("level three", 32'h03, {27'h0, userIntOff, cpuPrio});
		wr(`ADR_SYS_CTRL, 32'h1);
		wr(`ADR_STATUS, 32'h000000a0);
		rdc("field locked", `ADR_STATUS, 32'h00000060);
		wr(`ADR_SYS_CTRL, 32'h0);
		wr(`ADR_CORE_CTRL, 32'h0000ffff);
		rdc("core write", `ADR_CORE_CTRL, 32'h00000004);
		@(posedge core_clk);
		chk("view enable", 32'h1, {31'h0, psvOut});
		prioHighSet <= 1'h1;
		@(posedge core_clk);
		prioHighSet <= 1'h0;
		rdc("extra level", `ADR_CORE_CTRL, 32'h0000000c);
		@(posedge core_clk);
		chk("level eleven", 32'h1b, {27'h0, userIntOff, cpuPrio});
		wr(`ADR_CORE_CTRL, 32'h0);
		rdc("core clear", `ADR_CORE_CTRL, 32'h0);
		repeat (2) @(posedge core_clk);
		chk("view off", 32'h0, {31'h0, psvOut});
		wr(8'h20, 32'h0000ffff);
		rdc("unmapped", 8'h20, 32'h0);
		$display("test registers done");
	endtask : test_regs

	task automatic test_alu();
		run_op(cpu_alu_pkg::OP_ADD, 1'h0, 16'h7fff, 16'h0001, 4'h5, 6'h00,
			16'h8000, 16'h0, 16'h010c);
		run_op(cpu_alu_pkg::OP_ADD, 1'h0, 16'hffff, 16'h0001, 4'h5, 6'h00,
			16'h0000, 16'h0, 16'h0103);
		run_op(cpu_alu_pkg::OP_SUB, 1'h0, 16'h0000, 16'h0001, 4'h5, 6'h00,
			16'hffff, 16'h0, 16'h0008);
		run_op(cpu_alu_pkg::OP_SUB, 1'h0, 16'h0005, 16'h0003, 4'h5, 6'h00,
			16'h0002, 16'h0, 16'h0101);
		run_op(cpu_alu_pkg::OP_ADD, 1'h1, 16'hab0f, 16'h0001, 4'h5, 6'h00,
			16'hcd10, 16'h0, 16'h0100);
		run_op(cpu_alu_pkg::OP_ADD, 1'h1, 16'hab7f, 16'h0001, 4'h5, 6'h00,
			16'hcd80, 16'h0, 16'h010c);
		run_op(cpu_alu_pkg::OP_AND, 1'h0, 16'hffff, 16'h0000, 4'h5, 6'h00,
			16'h0000, 16'h0, 16'h0002);
		run_op(cpu_alu_pkg::OP_IOR, 1'h0, 16'h8000, 16'h0001, 4'h5, 6'h00,
			16'h8001, 16'h0, 16'h0008);
		run_op(cpu_alu_pkg::OP_XOR, 1'h0, 16'haaaa, 16'haaaa, 4'h5, 6'h00,
			16'h0000, 16'h0, 16'h0002);
		run_op(cpu_alu_pkg::OP_SHL, 1'h0, 16'h8000, 16'h0, 4'h5, 6'h04,
			16'h0800, 16'h0, 16'h0000);
		run_op(cpu_alu_pkg::OP_SHA, 1'h0, 16'h8000, 16'h0, 4'h5, 6'h04,
			16'hf800, 16'h0, 16'h0008);
		run_op(cpu_alu_pkg::OP_SHL, 1'h0, 16'h0001, 16'h0, 4'h5, 6'h3c,
			16'h0010, 16'h0, 16'h0000);
		run_op(cpu_alu_pkg::OP_SHL, 1'h0, 16'h1234, 16'h0, 4'h5, 6'h00,
			16'h1234, 16'h0, 16'h0000);
		run_op(cpu_alu_pkg::OP_SHA, 1'h0, 16'h8000, 16'h0, 4'h5, 6'h10,
			16'hffff, 16'h0, 16'h0008);
		run_op(cpu_alu_pkg::OP_SHL, 1'h0, 16'h0001, 16'h0, 4'h5, 6'h30,
			16'h0000, 16'h0, 16'h0002);
		run_op(cpu_alu_pkg::OP_MUL_SS, 1'h0, 16'hffff, 16'h0002, 4'h5,
			6'h00, 16'hfffe, 16'hffff, 16'h0);
		run_op(cpu_alu_pkg::OP_MUL_UU, 1'h0, 16'hffff, 16'h0002, 4'h5,
			6'h00, 16'hfffe, 16'h0001, 16'h0);
		run_op(cpu_alu_pkg::OP_MUL_US, 1'h0, 16'hffff, 16'hfffe, 4'h5,
			6'h00, 16'h0002, 16'hfffe, 16'h0);
		run_op(cpu_alu_pkg::OP_MUL_SU, 1'h0, 16'hffff, 16'hfffe, 4'h5,
			6'h00, 16'h0002, 16'hffff, 16'h0);
		run_op(cpu_alu_pkg::OP_MUL_SL, 1'h0, 16'hffff, 16'h0, 4'hf,
			6'h00, 16'hfff1, 16'hffff, 16'h0);
		run_op(cpu_alu_pkg::OP_MUL_UL, 1'h0, 16'hffff, 16'h0, 4'hf,
			6'h00, 16'hfff1, 16'h000e, 16'h0);
		run_op(cpu_alu_pkg::OP_MUL_BB, 1'h0, 16'h12ff, 16'h34ff, 4'h5,
			6'h00, 16'hfe01, 16'h0000, 16'h0);
		wr(`ADR_MEM_OPND, 32'h5);
		wr(wa(4'h5), 32'h3);
		wr(`ADR_COMMAND, cmd(cpu_alu_pkg::OP_ADD, 1'h0, 4'h0, 4'h5, 6'h00)
			| 32'hc0);
		rdc("memory result", `ADR_MEM_RESULT, 32'h8);
		$display("test alu done");
	endtask : test_alu

	// A command issued while the divide runs must be dropped
	task automatic run_div(input logic [4:0] op, input logic [31:0] a,
		input logic [15:0] b, input logic [15:0] q, input logic [15:0] r);
		logic [31:0] v;
		int n;
		wr(wa(4'h4), {16'h0, a[15:0]});
		wr(wa(4'h5), {16'h0, a[31:16]});
		wr(wa(4'h6), {16'h0, b});
		wr(wa(4'h2), 32'h0000cdcd);
		wr(`ADR_STATUS, 32'h0);
		wr(`ADR_COMMAND, cmd(op, 1'h0, 4'h4, 4'h6, 6'h00));
		rdc("loop active", `ADR_STATUS, 32'h00000010);
		wr(`ADR_COMMAND, cmd(cpu_alu_pkg::OP_ADD, 1'h0, 4'h4, 4'h6, 6'h00));
		n = 0;
		do begin
			bus(1'h0, `ADR_COMMAND, 32'h0, v);
			n++;
		end while (v[0] !== 1'h0 && n < 40);
		chk("divide busy", 32'h0, {31'h0, v[0]});
		@(posedge core_clk);
		rdc("quotient", wa(4'h0), {16'h0, q});
		rdc("remainder", wa(4'h1), {16'h0, r});
		rdc("busy ignore", wa(4'h2), 32'h0000cdcd);
		rdc("loop done", `ADR_STATUS, 32'h0);
		chk("loop length", 32'd19, 32'(raLast));
	endtask : run_div

	task automatic test_div();
		run_div(cpu_alu_pkg::OP_DIV_U32, 32'h00010000, 16'h0003, 16'h5555,
			16'h0001);
		run_div(cpu_alu_pkg::OP_DIV_S32, 32'hfffffff9, 16'h0002, 16'hfffd,
			16'hffff);
		run_div(cpu_alu_pkg::OP_DIV_S16, 32'h1234fff9, 16'h0002, 16'hfffd,
			16'hffff);
		run_div(cpu_alu_pkg::OP_DIV_U16, 32'h1234fff9, 16'h0002, 16'h7ffc,
			16'h0001);
		$display("test divide done");
	endtask : test_div

	// Enable low must hold every register, even against a hardware set
	task automatic test_freeze();
		wr(`ADR_CORE_CTRL, 32'h00000004);
		clkEn <= 1'h0;
		prioHighSet <= 1'h1;
		repeat (3) @(posedge core_clk);
		prioHighSet <= 1'h0;
		clkEn <= 1'h1;
		rdc("frozen level", `ADR_CORE_CTRL, 32'h00000004);
		rst <= 1'h1;
		@(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		chk("outputs mid reset", 32'h0,
			{25'h0, raOut, psvOut, userIntOff, cpuPrio});
		rdc("core mid reset", `ADR_CORE_CTRL, 32'h0);
		$display("test freeze done");
	endtask : test_freeze

	initial begin
		errors = 0;
		compares = 0;
		raRun = 0;
		raLast = 0;
		rst = 1'h1;
		clkEn = 1'h1;
		wbCyc = 1'h0;
		wbStb = 1'h0;
		wbWe = 1'h0;
		wbAdr = 8'h00;
		wbDatI = 32'h0;
		wbSel = 4'h0;
		prioHighSet = 1'h0;
		repeat (16) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		chk("outputs at reset", 32'h0,
			{25'h0, raOut, psvOut, userIntOff, cpuPrio});
		test_regs();
		test_alu();
		test_div();
		test_freeze();
		give_verdict();
	end
endmodule : cpu_alu_status_datapath_tb
`default_nettype wire
